// ==== logic/pbc_power_ctrl.sv ====
// Button, charge indicator, charger sequencing and strap decode for a power bank
//
// How it works
// R1: 80 ms to 2 s press is short
// R2: Short press lights indicator, starts boost
// R3: Standard: long press toggles flashlight
// R4: Press under 80 ms ignored
// R5: Two shorts within 1 s: all off
// R6: Alternative variant: long acts as short
// R7: Four-LED discharge levels, 1 Hz low blink
// R8: Charging: steady quarters, next blinks 1.5 Hz
// R9: Three-LED mode at thirds
// R10: Two-LED mode charge/discharge patterns
// R11: Single-LED mode patterns
// R12: Voltage strap picks battery type
// R13: Platform strap picks high or low
// R14: Thresholds per platform and battery type
// R15: Impedance strap picks compensation resistance
// R16: Phone plug-in wakes boost
// R17: Trickle, CC, CV, recharge below 4.1 V
// R18: Load over 1 A adds 100 mV
// R19: Current strap picks charge current
// R20: One charger-port signature on data lines
// R21: Light load for 32 s enters standby
// R22: Millisecond tick; classify on release
// R23: Periodic compensated samples set charge level
`timescale 1ns/1ps
module pbc_power_ctrl #(
  parameter int unsigned TICK_CYCLES  = pbc_pkg::TICK_CYCLES,
  parameter int unsigned LOAD_IDLE_MS = pbc_pkg::LOAD_IDLE_MS
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              button_n,
  input  wire logic [1:0]        battery_voltage_strap,
  input  wire logic              platform_strap,
  input  wire logic [2:0]        impedance_strap,
  input  wire logic [2:0]        charge_current_strap,
  input  wire logic              charger_present,
  input  wire logic              phone_plug,
  input  wire logic [12:0]       cell_mv,
  input  wire logic [12:0]       load_ma,
  input  wire logic [12:0]       charge_ma,
  output logic                   boost_en,
  output logic [12:0]            boost_setpoint_mv,
  output logic                   flashlight_on,
  output logic                   standby,
  output logic                   soc_led_first,
  output logic                   soc_led_second,
  output logic                   soc_led_third,
  output logic                   soc_led_fourth,
  output pbc_pkg::pbc_chg_e      charge_phase,
  output logic [11:0]            charge_current_ma,
  output logic [12:0]            cv_target_mv,
  output logic [1:0]             port_signature
);
  import pbc_pkg::*;

  function automatic logic [3:0] pbc_fill(input logic [2:0] n);
    case (n)
      3'h0:    pbc_fill = 4'h0;
      3'h1:    pbc_fill = 4'h1;
      3'h2:    pbc_fill = 4'h3;
      3'h3:    pbc_fill = 4'h7;
      default: pbc_fill = 4'hf;
    endcase
  endfunction : pbc_fill

  function automatic logic [3:0] pbc_onehot(input logic [2:0] n);
    case (n)
      3'h0:    pbc_onehot = 4'h1;
      3'h1:    pbc_onehot = 4'h2;
      3'h2:    pbc_onehot = 4'h4;
      default: pbc_onehot = 4'h8;
    endcase
  endfunction : pbc_onehot

  // Millisecond tick
  logic [31:0] tick_cnt_reg;
  logic        ms_tick;
  assign ms_tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1)); // R22

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      tick_cnt_reg <= 32'h0;
    else
      tick_cnt_reg <= ms_tick ? 32'h0 : tick_cnt_reg + 32'h1;

  // APB slave, fixed zero-wait answer
  logic [5:0]  ctrl_reg;
  logic        apb_setup;
  logic        apb_write;
  logic        addr_hit;
  logic [31:0] rd_mux;
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;
  assign addr_hit  = (paddr == CTRL_OFS) | (paddr == STATUS_OFS) | (paddr == STRAP_OFS) | (paddr == CELL_OFS);

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~addr_hit;
      prdata  <= apb_setup ? rd_mux : 32'h0;
    end

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      ctrl_reg <= CTRL_RESET;
    else if (apb_write && paddr == CTRL_OFS)
      ctrl_reg <= pwdata[5:0];

  logic       alt_variant;
  logic       flash_fitted;
  logic [1:0] led_mode;
  assign alt_variant  = ctrl_reg[CTRL_ALT_BIT];
  assign flash_fitted = ctrl_reg[CTRL_FLASH_BIT];
  assign led_mode     = ctrl_reg[CTRL_MODE_LSB +: 2];

  // Strap decode, registered every cycle so outputs stay flop-driven
  logic        batt_42_reg;
  logic        plat_high_reg;
  logic [10:0] imp_reg;
  logic [12:0] cv_next;
  logic [10:0] imp_next;
  logic [11:0] charge_current_strap_next;
  assign cv_next = (battery_voltage_strap == VS_GND) ? CV_435_MV :
                   (battery_voltage_strap == VS_VDD) ? CV_44_MV : CV_42_MV; // R12
  assign imp_next = (impedance_strap == 3'h0) ? IMP_10K :
                    (impedance_strap == 3'h1) ? IMP_43K :
                    (impedance_strap == 3'h2) ? IMP_120K :
                    (impedance_strap == 3'h3) ? IMP_200K : IMP_OPEN; // R15
  assign charge_current_strap_next = (charge_current_strap == 3'h0) ? CHARGE_CURRENT_STRAP_120K :
                     (charge_current_strap == 3'h1) ? CHARGE_CURRENT_STRAP_100K :
                     (charge_current_strap == 3'h2) ? CHARGE_CURRENT_STRAP_82K :
                     (charge_current_strap == 3'h3) ? CHARGE_CURRENT_STRAP_56K : CHARGE_CURRENT_STRAP_OPEN; // R19

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      batt_42_reg       <= 1'b1;
      plat_high_reg     <= 1'b1;
      imp_reg           <= IMP_OPEN;
      cv_target_mv      <= CV_42_MV;
      charge_current_ma <= CHARGE_CURRENT_STRAP_OPEN;
      port_signature    <= 2'h0;
    end
    else
    begin
      batt_42_reg       <= (cv_next == CV_42_MV); // R12
      plat_high_reg     <= platform_strap; // R13
      imp_reg           <= imp_next;
      cv_target_mv      <= cv_next;
      charge_current_ma <= charge_current_strap_next;
      port_signature    <= ctrl_reg[CTRL_DCP_LSB +: 2]; // R20
    end

  // Compensated cell voltage, sampled periodically to keep the indicator from flickering
  logic [23:0] drop_prod;
  logic [12:0] drop_mv;
  logic [13:0] comp_up;
  logic [12:0] comp_now;
  logic [12:0] comp_reg;
  logic [6:0]  sample_cnt_reg;
  assign drop_prod = 24'(charger_present ? charge_ma : load_ma) * 24'(imp_reg);
  assign drop_mv   = 13'(drop_prod / IMP_SCALE);
  assign comp_up   = {1'b0, cell_mv} + {1'b0, drop_mv};
  assign comp_now  = charger_present ? ((cell_mv > drop_mv) ? cell_mv - drop_mv : 13'h0) :
                     (comp_up[13] ? 13'h1fff : comp_up[12:0]);

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      sample_cnt_reg <= 7'h0;
      comp_reg       <= 13'h0;
    end
    else if (ms_tick)
    begin
      sample_cnt_reg <= (sample_cnt_reg == 7'(SAMPLE_MS - 1)) ? 7'h0 : sample_cnt_reg + 7'h1;
      if (sample_cnt_reg == 7'h0)
        comp_reg <= comp_now; // R23
    end

  // Level from selected threshold set
  logic [12:0] thr3;
  logic [12:0] thr2;
  logic [12:0] thr1;
  logic [2:0]  lvl;
  logic        low_batt;
  logic        empty_batt;
  assign thr3 = plat_high_reg ? HI_T3_MV : LO_T3_MV; // R14
  assign thr2 = plat_high_reg ? HI_T2_MV : LO_T2_MV; // R14
  assign thr1 = plat_high_reg ? (batt_42_reg ? HI_T1_42_MV : HI_T1_MV) : LO_T1_MV; // R14
  assign lvl  = (comp_reg >= thr3) ? 3'h4 : (comp_reg >= thr2) ? 3'h3 : (comp_reg >= thr1) ? 3'h2 : 3'h1;
  assign low_batt   = comp_reg < BLINK_MV; // R14
  assign empty_batt = comp_reg < EMPTY_MV;

  // Charger sequencing
  pbc_chg_e chg_reg;
  pbc_chg_e chg_next;
  always_comb
  begin
    chg_next = chg_reg;
    if (!charger_present)
      chg_next = CHG_IDLE;
    else
      unique case (chg_reg)
        CHG_IDLE:    chg_next = (cell_mv < TRICKLE_MV) ? CHG_TRICKLE : CHG_CC; // R17
        CHG_TRICKLE: chg_next = (cell_mv >= TRICKLE_MV) ? CHG_CC : CHG_TRICKLE; // R17
        CHG_CC:      chg_next = (cell_mv >= cv_target_mv) ? CHG_CV : CHG_CC; // R17
        CHG_CV:      chg_next = (charge_ma < STOP_MA) ? CHG_DONE : CHG_CV;
        CHG_DONE:    chg_next = (cell_mv < RECHARGE_MV) ? CHG_IDLE : CHG_DONE; // R17
      endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      chg_reg <= CHG_IDLE;
    else
      chg_reg <= chg_next;
  assign charge_phase = chg_reg;

  // Button timing
  logic        btn_prev_reg;
  logic [11:0] press_ms_reg;
  logic        release_evt;
  logic        is_short;
  logic        is_long;
  logic        act_short;
  logic        act_long;
  logic        dbl_armed_reg;
  logic [9:0]  dbl_ms_reg;
  logic        double_evt;
  logic        first_short;
  assign release_evt = btn_prev_reg & button_n; // R22
  assign is_short    = (press_ms_reg > 12'(SHORT_MIN_MS)) && (press_ms_reg < 12'(LONG_MS)); // R1 R4
  assign is_long     = press_ms_reg >= 12'(LONG_MS); // R3
  assign act_short   = release_evt & (is_short | (is_long & alt_variant)); // R6
  assign act_long    = release_evt & is_long & ~alt_variant; // R3
  assign double_evt  = act_short & dbl_armed_reg; // R5
  assign first_short = act_short & ~dbl_armed_reg;

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      btn_prev_reg <= 1'b0;
      press_ms_reg <= 12'h0;
    end
    else
    begin
      btn_prev_reg <= ~button_n;
      if (button_n)
        press_ms_reg <= 12'h0;
      else if (ms_tick && press_ms_reg <= 12'(LONG_MS))
        press_ms_reg <= press_ms_reg + 12'h1; // R22
    end

  // Double-press window opens on the first short press
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      dbl_armed_reg <= 1'b0;
      dbl_ms_reg    <= 10'h0;
    end
    else if (act_short)
    begin
      dbl_armed_reg <= ~dbl_armed_reg; // R5
      dbl_ms_reg    <= 10'h0;
    end
    else if (dbl_armed_reg && ms_tick)
    begin
      dbl_ms_reg <= dbl_ms_reg + 10'h1;
      if (dbl_ms_reg == 10'(DOUBLE_MS - 1))
        dbl_armed_reg <= 1'b0; // R5
    end

  // Power state
  logic        leds_on_reg;
  logic [15:0] idle_ms_reg;
  logic        idle_done;
  assign idle_done = ms_tick && (idle_ms_reg == 16'(LOAD_IDLE_MS - 1));

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      idle_ms_reg <= 16'h0;
    else if (!boost_en || load_ma >= IDLE_LOAD_MA || act_short || phone_plug)
      idle_ms_reg <= 16'h0;
    else if (ms_tick)
      idle_ms_reg <= idle_done ? 16'h0 : idle_ms_reg + 16'h1; // R21

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      boost_en      <= 1'b0;
      leds_on_reg   <= 1'b0;
      flashlight_on <= 1'b0;
    end
    else if (double_evt)
    begin
      boost_en      <= 1'b0; // R5
      leds_on_reg   <= 1'b0;
      flashlight_on <= 1'b0;
    end
    else
    begin
      if (first_short)
      begin
        boost_en    <= 1'b1; // R2
        leds_on_reg <= 1'b1;
      end
      else if (phone_plug)
        boost_en <= 1'b1; // R16
      else if (idle_done)
      begin
        boost_en    <= 1'b0; // R21
        leds_on_reg <= 1'b0;
      end
      if (act_long && flash_fitted)
        flashlight_on <= ~flashlight_on; // R3
      else if (!flash_fitted)
        flashlight_on <= 1'b0;
    end

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      standby           <= 1'b1;
      boost_setpoint_mv <= BOOST_MV;
    end
    else
    begin
      standby           <= ~boost_en & ~flashlight_on & ~charger_present; // R21
      boost_setpoint_mv <= (load_ma > CABLE_LOAD_MA) ? BOOST_MV + CABLE_STEP_MV : BOOST_MV; // R18
    end

  // Blink generators
  logic [9:0] slow_ms_reg;
  logic [9:0] fast_ms_reg;
  logic       blink_slow_reg;
  logic       blink_fast_reg;

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      slow_ms_reg    <= 10'h0;
      fast_ms_reg    <= 10'h0;
      blink_slow_reg <= 1'b0;
      blink_fast_reg <= 1'b0;
    end
    else if (ms_tick)
    begin
      slow_ms_reg <= (slow_ms_reg == 10'(BLINK_SLOW_HALF_MS - 1)) ? 10'h0 : slow_ms_reg + 10'h1;
      fast_ms_reg <= (fast_ms_reg == 10'(BLINK_FAST_HALF_MS - 1)) ? 10'h0 : fast_ms_reg + 10'h1;
      if (slow_ms_reg == 10'(BLINK_SLOW_HALF_MS - 1))
        blink_slow_reg <= ~blink_slow_reg;
      if (fast_ms_reg == 10'(BLINK_FAST_HALF_MS - 1))
        blink_fast_reg <= ~blink_fast_reg;
    end

  // Indicator patterns
  logic [2:0] lit_cnt;
  logic [2:0] steady_cnt;
  logic [3:0] pat_multi_dis;
  logic [3:0] pat_multi_chg;
  logic [3:0] pat_two;
  logic [3:0] pat_one;
  logic [3:0] pat_sel;
  logic       charging;
  logic       chg_full;
  logic       show;
  assign charging   = charger_present;
  assign chg_full   = chg_reg == CHG_DONE;
  assign show       = charger_present | leds_on_reg;
  // Three-LED mode folds four bands onto thirds
  assign lit_cnt    = (led_mode == MODE_3LED && lvl == 3'h4) ? 3'h3 : lvl; // R9
  assign steady_cnt = lit_cnt - 3'h1;
  assign pat_multi_dis = empty_batt ? 4'h0 : low_batt ? {3'h0, blink_slow_reg} : pbc_fill(lit_cnt); // R7
  assign pat_multi_chg = chg_full ? pbc_fill((led_mode == MODE_3LED) ? 3'h3 : 3'h4) :
                         (pbc_fill(steady_cnt) | (blink_fast_reg ? pbc_onehot(steady_cnt) : 4'h0)); // R8
  assign pat_two = charging ? (chg_full ? 4'h0 : 4'h1) :
                   empty_batt ? 4'h0 : {2'h0, (low_batt ? blink_slow_reg : 1'b1), 1'b0}; // R10
  assign pat_one = charging ? {3'h0, chg_full | blink_fast_reg} :
                   empty_batt ? 4'h0 : {3'h0, low_batt ? blink_slow_reg : 1'b1}; // R11
  assign pat_sel = ~show ? 4'h0 :
                   (led_mode == MODE_2LED) ? pat_two :
                   (led_mode == MODE_1LED) ? pat_one :
                   charging ? pat_multi_chg : pat_multi_dis;

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      soc_led_first  <= 1'b0;
      soc_led_second <= 1'b0;
      soc_led_third  <= 1'b0;
      soc_led_fourth <= 1'b0;
    end
    else
    begin
      soc_led_first  <= pat_sel[0];
      soc_led_second <= pat_sel[1];
      soc_led_third  <= pat_sel[2];
      soc_led_fourth <= pat_sel[3];
    end

  // Read data
  logic [31:0] status_word;
  logic [31:0] strap_word;
  assign status_word = {18'h0, 1'b0, chg_reg, lvl, low_batt, empty_batt,
                        leds_on_reg, standby, flashlight_on, boost_en, charger_present};
  assign strap_word  = {1'b0, plat_high_reg, batt_42_reg, 1'b0, imp_reg, 1'b0, charge_current_ma,
                        battery_voltage_strap, platform_strap, 1'b0};
  assign rd_mux = (paddr == CTRL_OFS)   ? {26'h0, ctrl_reg} :
                  (paddr == STATUS_OFS) ? status_word :
                  (paddr == STRAP_OFS)  ? strap_word :
                  (paddr == CELL_OFS)   ? {19'h0, comp_reg} : 32'h0;
endmodule : pbc_power_ctrl

// ==== logic/pbc_pkg.sv ====
// Shared constants and types for the power bank control block
package pbc_pkg;
  // Time base
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned TICK_PERIOD_NS  = 1_000_000;
  localparam int unsigned TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SHORT_MIN_MS    = 80;
  localparam int unsigned LONG_MS         = 2000;
  localparam int unsigned DOUBLE_MS       = 1000;
  localparam int unsigned BLINK_SLOW_HZ_X10 = 10;
  localparam int unsigned BLINK_FAST_HZ_X10 = 15;
  localparam int unsigned BLINK_SLOW_HALF_MS = 10_000 / (2 * BLINK_SLOW_HZ_X10);
  localparam int unsigned BLINK_FAST_HALF_MS = 10_000 / (2 * BLINK_FAST_HZ_X10);
  localparam int unsigned LOAD_IDLE_MS    = 32_000;
  localparam int unsigned SAMPLE_MS       = 64;
  // Analog levels, mV and mA
  localparam logic [12:0] TRICKLE_MV      = 13'h0bb8;
  localparam logic [12:0] RECHARGE_MV     = 13'h1004;
  localparam logic [12:0] CV_42_MV        = 13'h1068;
  localparam logic [12:0] CV_435_MV       = 13'h10fe;
  localparam logic [12:0] CV_44_MV        = 13'h1130;
  localparam logic [12:0] HI_T3_MV        = 13'h0fb4;
  localparam logic [12:0] HI_T2_MV        = 13'h0f00;
  localparam logic [12:0] HI_T1_42_MV     = 13'h0e4c;
  localparam logic [12:0] HI_T1_MV        = 13'h0e88;
  localparam logic [12:0] LO_T3_MV        = 13'h0f3c;
  localparam logic [12:0] LO_T2_MV        = 13'h0e88;
  localparam logic [12:0] LO_T1_MV        = 13'h0e10;
  localparam logic [12:0] BLINK_MV        = 13'h0ce4;
  localparam logic [12:0] EMPTY_MV        = 13'h0bb8;
  localparam logic [12:0] STOP_MA         = 13'h0190;
  localparam logic [12:0] IDLE_LOAD_MA    = 13'h002d;
  localparam logic [12:0] CABLE_LOAD_MA   = 13'h03e8;
  localparam logic [12:0] BOOST_MV        = 13'h1388;
  localparam logic [12:0] CABLE_STEP_MV   = 13'h0064;
  // Impedance in tenths of a milliohm
  localparam logic [10:0] IMP_10K         = 11'h1c2;
  localparam logic [10:0] IMP_43K         = 11'h2a3;
  localparam logic [10:0] IMP_120K        = 11'h465;
  localparam logic [10:0] IMP_200K        = 11'h384;
  localparam logic [10:0] IMP_OPEN        = 11'h0e1;
  localparam logic [23:0] IMP_SCALE       = 24'h002710;
  // Charge current settings, mA
  localparam logic [11:0] CHARGE_CURRENT_STRAP_120K       = 12'h3e8;
  localparam logic [11:0] CHARGE_CURRENT_STRAP_100K       = 12'h4b0;
  localparam logic [11:0] CHARGE_CURRENT_STRAP_82K        = 12'h5dc;
  localparam logic [11:0] CHARGE_CURRENT_STRAP_56K        = 12'h834;
  localparam logic [11:0] CHARGE_CURRENT_STRAP_OPEN       = 12'h708;
  // Strap codes
  localparam logic [1:0]  VS_FLOAT        = 2'h0;
  localparam logic [1:0]  VS_GND          = 2'h1;
  localparam logic [1:0]  VS_VDD          = 2'h2;
  // LED modes
  localparam logic [1:0]  MODE_4LED       = 2'h0;
  localparam logic [1:0]  MODE_3LED       = 2'h1;
  localparam logic [1:0]  MODE_2LED       = 2'h2;
  localparam logic [1:0]  MODE_1LED       = 2'h3;
  // Register map
  localparam logic [11:0] CTRL_OFS        = 12'h000;
  localparam logic [11:0] STATUS_OFS      = 12'h004;
  localparam logic [11:0] STRAP_OFS       = 12'h008;
  localparam logic [11:0] CELL_OFS        = 12'h00c;
  localparam int unsigned CTRL_ALT_BIT    = 0;
  localparam int unsigned CTRL_FLASH_BIT  = 1;
  localparam int unsigned CTRL_MODE_LSB   = 2;
  localparam int unsigned CTRL_DCP_LSB    = 4;
  localparam logic [5:0]  CTRL_RESET      = 6'h02;
  typedef enum logic [2:0] {CHG_IDLE, CHG_TRICKLE, CHG_CC, CHG_CV, CHG_DONE} pbc_chg_e;
endpackage : pbc_pkg

// ==== verification/pbc_far_side.sv ====
// Model of the push button and phone plug detector beside the block
`timescale 1ns/1ps
module pbc_far_side #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input  wire logic core_clk,
  output logic      button_n,
  output logic      phone_plug
);
  // Key has a pull-up, so a released key reads high
  initial
  begin
    button_n   = 1'b1;
    phone_plug = 1'b0;
  end

  // Gap after release keeps presses apart but well inside the pairing window
  task automatic press(input int unsigned ms);
    @(posedge core_clk);
    button_n <= 1'b0;
    repeat (ms * TICK_CYCLES) @(posedge core_clk);
    button_n <= 1'b1;
    repeat (20) @(posedge core_clk);
  endtask : press

  task automatic plug();
    @(posedge core_clk);
    phone_plug <= 1'b1;
    @(posedge core_clk);
    phone_plug <= 1'b0;
  endtask : plug
endmodule : pbc_far_side

// ==== verification/pbc_power_ctrl_asserts.sv ====
// Port-level assertions for the power bank control block
`timescale 1ns/1ps
module pbc_power_ctrl_asserts
  import pbc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        button_n,
  input wire logic        phone_plug,
  input wire logic        charger_present,
  input wire logic [12:0] load_ma,
  input wire logic        boost_en,
  input wire logic [12:0] boost_setpoint_mv,
  input wire logic        flashlight_on,
  input wire logic        standby,
  input wire logic [1:0]  port_signature
);
  logic [31:0] press_reg;
  logic        alt_reg;
  wire         ctrl_wr = psel && penable && pready && pwrite && paddr == CTRL_OFS;

  // Press length in cycles, still intact at the release edge
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      press_reg <= 32'h0;
      alt_reg   <= 1'b0;
    end
    else
    begin
      press_reg <= button_n ? 32'h0 : press_reg + 32'h1;
      if (ctrl_wr)
        alt_reg <= pwdata[CTRL_ALT_BIT];
    end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Margins of one tick allow for the tick phase against the press
  sequence short_seq;
    $rose(button_n) && press_reg > 81 * TICK_CYCLES && press_reg < 1999 * TICK_CYCLES;
  endsequence
  sequence long_seq;
    $rose(button_n) && press_reg > 2001 * TICK_CYCLES;
  endsequence

  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_err_map: assert property (pready |-> pslverr == (paddr > CELL_OFS))
    else $error("pslverr wrong for address");
  a_sig_write: assert property (ctrl_wr |-> ##2 port_signature == $past(pwdata[5:4], 2))
    else $error("port signature not from write");
  a_cable_comp: assert property (1'b1 |=> boost_setpoint_mv ==
    ($past(load_ma) > CABLE_LOAD_MA ? BOOST_MV + CABLE_STEP_MV : BOOST_MV))
    else $error("boost setpoint wrong for load");
  a_standby_idle: assert property (1'b1 |=> standby ==
    $past(!boost_en && !flashlight_on && !charger_present))
    else $error("standby wrong");
  a_phone_wake: assert property ($rose(phone_plug) |-> ##[1:4] boost_en)
    else $error("plug-in did not start boost");
  a_short_on: assert property (short_seq ##0 !boost_en |-> ##[1:3] boost_en)
    else $error("short press did not start boost");
  a_tiny_ignored: assert property ($rose(button_n) && press_reg < 79 * TICK_CYCLES |=>
    ($stable(boost_en) && $stable(flashlight_on)) [*3])
    else $error("brief press had an effect");
  a_long_flash: assert property (long_seq ##0 !alt_reg && !flashlight_on |-> ##[1:3] flashlight_on)
    else $error("long press did not light flashlight");
  a_long_alt: assert property (long_seq ##0 alt_reg && !boost_en |-> ##[1:3] boost_en)
    else $error("long press in variant not short");
endmodule : pbc_power_ctrl_asserts

bind pbc_power_ctrl pbc_power_ctrl_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// ==== verification/pbc_power_ctrl_tb.sv ====
// Self-checking bench for the power bank control block
`timescale 1ns/1ps
module pbc_power_ctrl_tb;
  import pbc_pkg::*;
  localparam int unsigned TK = 10;
  logic        core_clk = 1'b0, rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, button_n, phone_plug, charger_present = 1'b0;
  logic [1:0]  battery_voltage_strap = 2'h0, port_signature;
  logic        platform_strap = 1'b1;
  logic [2:0]  impedance_strap = 3'h4, charge_current_strap = 3'h4;
  logic [12:0] cell_mv = 13'h1004, load_ma = 13'h0064, charge_ma = 13'h0000;
  logic [12:0] boost_setpoint_mv, cv_target_mv;
  logic        boost_en, flashlight_on, standby;
  logic        soc_led_first, soc_led_second, soc_led_third, soc_led_fourth;
  wire [3:0]   led_bus = {soc_led_fourth, soc_led_third, soc_led_second, soc_led_first};
  logic [11:0] charge_current_ma;
  pbc_chg_e    charge_phase;
  int          err_count = 0, check_count = 0;

  typedef struct packed {
    logic [1:0]  vs;
    logic [2:0]  ic;
    logic [12:0] mv;
    logic [3:0]  leds;
    logic [12:0] cv;
    logic [11:0] ma;
  } pbc_row_s;
  // High platform, open impedance strap, 100 mA load; LEDs as {fourth..first}
  pbc_row_s rows [4] = '{
    '{2'h1, 3'h0, 13'h1004, 4'hf, CV_435_MV, CHARGE_CURRENT_STRAP_120K},
    '{2'h2, 3'h1, 13'h0f3c, 4'h7, CV_44_MV, CHARGE_CURRENT_STRAP_100K},
    '{2'h0, 3'h2, 13'h0e74, 4'h3, CV_42_MV, CHARGE_CURRENT_STRAP_82K},
    '{2'h3, 3'h3, 13'h0dac, 4'h1, CV_42_MV, CHARGE_CURRENT_STRAP_56K}
  };

  pbc_power_ctrl #(.TICK_CYCLES(TK), .LOAD_IDLE_MS(50)) u_dut (.*);
  pbc_far_side #(.TICK_CYCLES(TK)) u_far (.*);

  always #2.5 core_clk = ~core_clk;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic wt(input int unsigned ms);
    repeat (ms * TK) @(posedge core_clk);
  endtask : wt

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk);
  endtask : apb

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk("standby", 32'h1, 32'(standby));
    chk("boost_en", 32'h0, 32'(boost_en));
    chk("setpoint", 32'(BOOST_MV), 32'(boost_setpoint_mv));
    chk("charge_current_ma", 32'(CHARGE_CURRENT_STRAP_OPEN), 32'(charge_current_ma));
    chk("cv_target_mv", 32'(CV_42_MV), 32'(cv_target_mv));
    chk("charge_phase", 32'(CHG_IDLE), 32'(charge_phase));
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic wrap_up();
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    do_reset();
    u_far.press(100);
    chk("boost_en", 32'h1, 32'(boost_en));
    foreach (rows[i])
    begin
      battery_voltage_strap <= rows[i].vs;
      charge_current_strap  <= rows[i].ic;
      cell_mv               <= rows[i].mv;
      // One sample period plus margin before the level settles
      wt(70);
      chk("leds", 32'(rows[i].leds), 32'(led_bus));
      chk("cv_target_mv", 32'(rows[i].cv), 32'(cv_target_mv));
      chk("charge_current_ma", 32'(rows[i].ma), 32'(charge_current_ma));
    end
    // Low platform and 10K strap lift 3597 mV over the lowest threshold
    platform_strap  <= 1'b0;
    impedance_strap <= 3'h0;
    cell_mv         <= 13'h0e0d;
    wt(70);
    chk("leds", 32'h3, 32'(led_bus));
    do_reset();
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", 32'(CTRL_RESET), rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("pslverr", 32'h1, 32'(err));
    chk("prdata", 32'h0, rd);
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, CTRL_OFS, 32'(s * 16 + 2));
      @(negedge core_clk);
      chk("port_signature", 32'(s), 32'(port_signature));
    end
    u_far.press(50);
    chk("boost_en", 32'h0, 32'(boost_en));
    u_far.press(80);
    chk("boost_en", 32'h0, 32'(boost_en));
    u_far.press(100);
    chk("boost_en", 32'h1, 32'(boost_en));
    u_far.press(100);
    chk("boost_en", 32'h0, 32'(boost_en));
    u_far.press(2100);
    chk("flashlight_on", 32'h1, 32'(flashlight_on));
    u_far.press(100);
    u_far.press(100);
    chk("flashlight_on", 32'h0, 32'(flashlight_on));
    chk("boost_en", 32'h0, 32'(boost_en));
    apb(1'b1, CTRL_OFS, 32'h3);
    u_far.press(2100);
    chk("boost_en", 32'h1, 32'(boost_en));
    chk("flashlight_on", 32'h0, 32'(flashlight_on));
    load_ma <= 13'h03e9;
    repeat (3) @(posedge core_clk);
    chk("setpoint", 32'h13ec, 32'(boost_setpoint_mv));
    load_ma <= 13'h03e8;
    repeat (3) @(posedge core_clk);
    chk("setpoint", 32'h1388, 32'(boost_setpoint_mv));
    load_ma <= 13'h0000;
    wt(60);
    chk("boost_en", 32'h0, 32'(boost_en));
    chk("standby", 32'h1, 32'(standby));
    load_ma <= 13'h0064;
    u_far.plug();
    repeat (4) @(posedge core_clk);
    chk("boost_en", 32'h1, 32'(boost_en));
    charger_present <= 1'b1;
    charge_ma <= 13'h0320;
    cell_mv <= 13'h0b54;
    wt(70);
    chk("charge_phase", 32'(CHG_TRICKLE), 32'(charge_phase));
    cell_mv <= 13'h0dac;
    wt(70);
    chk("charge_phase", 32'(CHG_CC), 32'(charge_phase));
    cell_mv <= 13'h1068;
    repeat (3) @(posedge core_clk);
    chk("charge_phase", 32'(CHG_CV), 32'(charge_phase));
    charge_ma <= 13'h0064;
    repeat (3) @(posedge core_clk);
    chk("charge_phase", 32'(CHG_DONE), 32'(charge_phase));
    chk("leds", 32'hf, 32'(led_bus));
    wrap_up();
  end

  initial
  begin
    repeat (80000) @(posedge core_clk);
    err_count++;
    wrap_up();
  end
endmodule : pbc_power_ctrl_tb
